/* File: src/ssi_regs.svh */
`ifndef SSI_REGS_SVH
`define SSI_REGS_SVH

// Register byte offsets
`define SSI_CTRL_OFS        12'h000
`define SSI_POS_OFS         12'h004
`define SSI_STATUS_OFS      12'h008

// Control register fields
`define SSI_CTRL_GRAY_BIT   0
`define SSI_CTRL_RING_BIT   1
`define SSI_CTRL_SPEC_BIT   2
`define SSI_CTRL_LEN_LSB    8
`define SSI_CTRL_LEN_MSB    12

// Status register fields
`define SSI_STAT_BUSY_BIT   0
`define SSI_STAT_RPT_BIT    1
`define SSI_STAT_DIR_BIT    2
`define SSI_STAT_CNT_LSB    16

// Reset values
`define SSI_GRAY_RESET      1'b1
`define SSI_RING_RESET      1'b0
`define SSI_SPEC_RESET      1'b0
`define SSI_LEN_RESET       5'h19
`define SSI_POS_RESET       30'h0000_0000

// Word length limits
`define SSI_LEN_MIN         5'h02
`define SSI_RING_MAX_LEN    5'h0d

// Timing
`define SSI_CLK_MHZ         250
`define SSI_MONO_US         20
`define SSI_MONO_CYCLES     (`SSI_MONO_US * `SSI_CLK_MHZ)
`define SSI_MONO_CNT_W      13
`define SSI_DIR_DELAY_MS    10

// AXI responses
`define SSI_RESP_OKAY       2'h0
`define SSI_RESP_SLVERR     2'h2

`endif

/* File: src/ssi_pkg.sv */
package ssi_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_TAIL  = 3'b100
   } state_type;

   typedef struct packed {
      logic [12:0] cnt;
      logic        running;
      logic        expired;
   } mono_type;

   typedef struct packed {
      state_type   state;
      logic [4:0]  idx;
      logic [30:0] shreg;
      logic        sdata;
      logic        repeating;
      logic [15:0] frames;
      logic        s1;
      logic        s2;
      logic        s3;
      logic        d1;
      logic        d2;
      logic        gray;
      logic        ring;
      logic        special;
      logic [4:0]  len;
      logic [29:0] pos;
      logic        awready;
      logic        aw_held;
      logic [31:0] aw_addr;
      logic        wready;
      logic        w_held;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } xmit_type;

endpackage

/* File: src/ssi_monoflop.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssi_regs.svh"

module ssi_monoflop #(
   parameter int unsigned CYCLES = `SSI_MONO_CYCLES
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Retrigger and timeout
   input  wire logic trigger,
   output var  logic expired
);

   ssi_pkg::mono_type mf_q;
   ssi_pkg::mono_type mf_d;

   always_comb begin
      mf_d = mf_q;
      mf_d.expired = 1'b0;
      // Every falling clock edge restarts the full timeout
      if (trigger) begin
         mf_d.cnt = `SSI_MONO_CNT_W'(CYCLES - 1);
         mf_d.running = 1'b1;
      end else if (mf_q.running) begin
         if (mf_q.cnt == '0) begin
            mf_d.running = 1'b0;
            mf_d.expired = 1'b1;
         end else begin
            mf_d.cnt = mf_q.cnt - `SSI_MONO_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mf_q <= '0;
      end else begin
         mf_q <= mf_d;
      end
   end

   assign expired = mf_q.expired;

endmodule // ssi_monoflop
`default_nettype wire

/* File: src/ssi_position_transmitter.sv */
// Operation
// - Idle clock and data lines both rest high between transfers.
// - First clock falling edge captures position and special bit, starting a transfer.
// - First rising edge places the captured word's MSB on data.
// - Each further rising edge presents the next lower bit.
// - After the LSB data goes low until monoflop timeout, then high.
// - Monoflop timeout restarts from each falling clock edge, ending at the last.
// - Unbroken clocking after the word repeats the same captured word.
// - Standard format uses 25 clock pulses per word, without repetition.
// - A late 26th pulse yields a freshly captured word instead of repeating.
// - Repetition is allowed only for words of at most 13 bits.
// - Master keeps edge gaps within a frame below the monoflop timeout.
// - Position has up to 16 single-turn plus 14 multiturn bits, 30 total.
// - Position is sent as Gray code or plain binary, selectable.
// - With direction input inactive, count decreases clockwise.
// - Direction input is active low; logic 0 reverses counting.
// - A direction change takes effect within 10 ms.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ssi_regs.svh"

module ssi_position_transmitter #(
   parameter int unsigned MONO_CYCLES = `SSI_MONO_CYCLES
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // AXI4-Lite write response
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   // AXI4-Lite read data
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial link
   input  wire logic        sclk_in,
   output var  logic        sdata_out,
   // Counting direction pin
   input  wire logic        dir_select_n
);

   ssi_pkg::xmit_type st_q;
   ssi_pkg::xmit_type st_d;

   logic        fall;
   logic        rise;
   logic        mono_expired;
   logic        dir_active;
   logic        ring_ok;
   logic [30:0] wmask;
   logic [29:0] bmask;
   logic [29:0] bin;
   logic [29:0] coded;
   logic [30:0] word;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;
   logic [31:0] pos_word;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [31:0] addr);
      logic hit;
      hit = (addr[31:12] == 20'h0_0000) &&
            ((addr[11:0] == `SSI_CTRL_OFS) ||
             (addr[11:0] == `SSI_POS_OFS) ||
             (addr[11:0] == `SSI_STATUS_OFS));
      return hit;
   endfunction

   // Sampled edges of the master clock, taken after the synchroniser
   assign fall = st_q.s3 & ~st_q.s2;
   assign rise = ~st_q.s3 & st_q.s2;

   ssi_monoflop #(
      .CYCLES (MONO_CYCLES)
   ) u_mono (
      .aclk    (aclk),
      .aresetn (aresetn),
      .trigger (fall),
      .expired (mono_expired)
   );

   // Direction pin is sampled continuously, so a change reaches the next frame in a few cycles
   assign dir_active = ~st_q.d2;

   // Repetition only for short words; longer ones drop low after the LSB
   assign ring_ok = st_q.ring && (st_q.len <= `SSI_RING_MAX_LEN);

   // Word assembly: position bits above the special bit, unused high bits forced to zero
   always_comb begin
      wmask = 31'((32'h1 << st_q.len) - 32'h1);
      bmask = wmask[30:1];
      // Raw count falls clockwise; complement reverses the direction
      bin   = (st_q.pos ^ {30{dir_active}}) & bmask;
      coded = st_q.gray ? (bin ^ (bin >> 1)) : bin;
      word  = {coded, st_q.special} & wmask;
   end

   always_comb begin
      ctrl_word = 32'h0;
      ctrl_word[`SSI_CTRL_GRAY_BIT] = st_q.gray;
      ctrl_word[`SSI_CTRL_RING_BIT] = st_q.ring;
      ctrl_word[`SSI_CTRL_SPEC_BIT] = st_q.special;
      ctrl_word[`SSI_CTRL_LEN_MSB:`SSI_CTRL_LEN_LSB] = st_q.len;
      stat_word = 32'h0;
      stat_word[`SSI_STAT_BUSY_BIT] = (st_q.state != ssi_pkg::ST_IDLE);
      stat_word[`SSI_STAT_RPT_BIT] = st_q.repeating;
      stat_word[`SSI_STAT_DIR_BIT] = dir_active;
      stat_word[`SSI_STAT_CNT_LSB +: 16] = st_q.frames;
      pos_word = {2'h0, st_q.pos};
   end

   always_comb begin
      logic [31:0] tmp;
      tmp = 32'h0;
      st_d = st_q;

      // Two-flop synchronisers for the link clock and the direction pin
      st_d.s1 = sclk_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.d1 = dir_select_n;
      st_d.d2 = st_q.d1;

      // Timeout ends any frame; a stalled master also lands here
      if (mono_expired && (st_q.state != ssi_pkg::ST_IDLE)) begin
         st_d.state = ssi_pkg::ST_IDLE;
         st_d.sdata = 1'b1;
         st_d.repeating = 1'b0;
         st_d.frames = st_q.frames + 16'h1;
      end

      case (st_d.state)
         ssi_pkg::ST_IDLE: begin
            st_d.sdata = 1'b1;
            // A late pulse finds the frame closed and captures anew
            if (fall) begin
               st_d.shreg = word;
               st_d.idx = st_q.len - 5'h1;
               st_d.state = ssi_pkg::ST_SHIFT;
            end
         end
         ssi_pkg::ST_SHIFT: begin
            if (rise) begin
               st_d.sdata = st_q.shreg[st_q.idx];
               if (st_q.idx == 5'h0) begin
                  st_d.state = ssi_pkg::ST_TAIL;
               end else begin
                  st_d.idx = st_q.idx - 5'h1;
               end
            end
         end
         ssi_pkg::ST_TAIL: begin
            // Pulse after the LSB decides repetition while the timeout runs
            if (rise && ring_ok) begin
               st_d.sdata = st_q.shreg[st_q.len - 5'h1];
               st_d.idx = st_q.len - 5'h2;
               st_d.state = ssi_pkg::ST_SHIFT;
               st_d.repeating = 1'b1;
            end else if (rise || fall) begin
               st_d.sdata = 1'b0;
            end
         end
         default: begin
            st_d.state = ssi_pkg::ST_IDLE;
            st_d.sdata = 1'b1;
         end
      endcase

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_held = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = mapped(st_q.aw_addr) ? `SSI_RESP_OKAY : `SSI_RESP_SLVERR;
         if (st_q.aw_addr[31:12] == 20'h0_0000) begin
            if (st_q.aw_addr[11:0] == `SSI_CTRL_OFS) begin
               tmp = merge(ctrl_word, st_q.wdata, st_q.wstrb);
               st_d.gray = tmp[`SSI_CTRL_GRAY_BIT];
               st_d.ring = tmp[`SSI_CTRL_RING_BIT];
               st_d.special = tmp[`SSI_CTRL_SPEC_BIT];
               // A word shorter than position plus special bit makes no sense
               if (tmp[`SSI_CTRL_LEN_MSB:`SSI_CTRL_LEN_LSB] < `SSI_LEN_MIN) begin
                  st_d.len = `SSI_LEN_MIN;
               end else begin
                  st_d.len = tmp[`SSI_CTRL_LEN_MSB:`SSI_CTRL_LEN_LSB];
               end
            end else if (st_q.aw_addr[11:0] == `SSI_POS_OFS) begin
               tmp = merge(pos_word, st_q.wdata, st_q.wstrb);
               st_d.pos = tmp[29:0];
            end
         end
      end
      st_d.awready = !st_d.aw_held;
      st_d.wready = !st_d.w_held;

      // Read channel: one read under way at a time
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
         st_d.arready = 1'b1;
      end
      if (s_axi_arvalid && st_q.arready) begin
         st_d.arready = 1'b0;
         st_d.rvalid = 1'b1;
         st_d.rresp = mapped(s_axi_araddr) ? `SSI_RESP_OKAY : `SSI_RESP_SLVERR;
         st_d.rdata = 32'h0;
         if (s_axi_araddr[31:12] == 20'h0_0000) begin
            case (s_axi_araddr[11:0])
               `SSI_CTRL_OFS: begin
                  st_d.rdata = ctrl_word;
               end
               `SSI_POS_OFS: begin
                  st_d.rdata = pos_word;
               end
               `SSI_STATUS_OFS: begin
                  st_d.rdata = stat_word;
               end
               default: begin
                  st_d.rdata = 32'h0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.state <= ssi_pkg::ST_IDLE;
         st_q.sdata <= 1'b1;
         st_q.s1 <= 1'b1;
         st_q.s2 <= 1'b1;
         st_q.s3 <= 1'b1;
         st_q.d1 <= 1'b1;
         st_q.d2 <= 1'b1;
         st_q.gray <= `SSI_GRAY_RESET;
         st_q.ring <= `SSI_RING_RESET;
         st_q.special <= `SSI_SPEC_RESET;
         st_q.len <= `SSI_LEN_RESET;
         st_q.pos <= `SSI_POS_RESET;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready  = st_q.wready;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = st_q.rdata;
   assign s_axi_rresp   = st_q.rresp;
   assign sdata_out     = st_q.sdata;

endmodule // ssi_position_transmitter
`default_nettype wire

/* File: test/ssi_position_transmitter_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ssi_position_transmitter_properties #(
   parameter int unsigned MONO_CYCLES = 5000
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Serial link
   input wire logic        sclk_in,
   input wire logic        sdata_out
);
   // Timeout runs from the last fall, the quiet count from the last edge of either kind
   localparam int unsigned QMIN = MONO_CYCLES - 8;
   logic        sclk_q;
   logic [15:0] quiet_q;
   always_ff @(posedge aclk) begin
      sclk_q <= sclk_in;
      if (!aresetn || sclk_in != sclk_q) quiet_q <= 16'h0;
      else if (quiet_q != 16'hffff) quiet_q <= quiet_q + 16'h1;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_reset_idle: assert property ($rose(aresetn) |-> sdata_out)
      else $error("data line not idle after reset");
   chk_start_hold: assert property ($fell(sclk_in) && sdata_out && quiet_q >= QMIN |-> sdata_out [*6])
      else $error("data moved on the capturing fall");
   chk_bit_timing: assert property ($changed(sdata_out) |-> quiet_q inside {[1:6]} || quiet_q >= QMIN)
      else $error("data changed away from a clock edge or timeout");
   chk_tail_release: assert property (quiet_q == MONO_CYCLES + 12 |-> sdata_out)
      else $error("data not released high after timeout");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid)
      else $error("write answer late");
   cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
   cover property ($rose(sdata_out) && quiet_q >= QMIN);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule // ssi_position_transmitter_properties
bind ssi_position_transmitter ssi_position_transmitter_properties #(.MONO_CYCLES(MONO_CYCLES)) chk_inst (.*);
`default_nettype wire

/* File: test/ssi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ssi_master_model (
   // Link
   output var  logic        sclk,
   input  wire logic        sdata,
   // Control
   input  wire logic        aclk,
   input  wire logic        start,
   input  wire logic [5:0]  npulses,
   output var  logic [31:0] word,
   output var  logic        done
);
   int          i;
   logic [31:0] w;
   initial begin
      sclk = 1'h1; // Clock rests high outside bundles
      done = 1'h0;
      word = '0;
      forever begin
         @(posedge start);
         #1.3;
         w = '0;
         for (i = 0; i < npulses; i++) begin
            sclk = 1'h0;
            #24;
            sclk = 1'h1; // Gaps far below the timeout; rate scaled to the short sim timeout
            #23;
            w = {w[30:0], sdata};
            #1;
         end
         // No new bundle before data returns high
         for (i = 0; i < 3000 && sdata !== 1'h1; i++) #4;
         word = (sdata === 1'h1) ? w : ~w;
         done = 1'h1;
         @(posedge aclk);
         #1;
         done = 1'h0;
      end
   end
endmodule // ssi_master_model
`default_nettype wire

/* File: test/test_ssi_position_transmitter.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ssi_position_transmitter;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [31:0] s_axi_awaddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [31:0] s_axi_araddr = '0;
   logic [2:0]  s_axi_awprot = '0;
   logic [2:0]  s_axi_arprot = '0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'h0;
   logic        s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0;
   logic        dir_select_n = 1'h1;
   logic        start = 1'h0;
   logic [5:0]  npulses = '0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        sclk_in, sdata_out, done;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, word;
   logic [31:0] exp_q [$];
   int          error_cnt = 0;
   int          compares = 0;
   int          seed;
   int          k;
   int          lens [4] = '{25, 31, 2, 14};

   always #2 aclk = ~aclk;

   ssi_position_transmitter #(.MONO_CYCLES(200)) ssi_position_transmitter_inst (.*);
   ssi_master_model ssi_master_model_inst (
      .sclk    (sclk_in),
      .sdata   (sdata_out),
      .aclk    (aclk),
      .start   (start),
      .npulses (npulses),
      .word    (word),
      .done    (done)
   );

   task report_and_stop;
      begin
         if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   task hang;
      begin
         error_cnt++;
         report_and_stop;
      end
   endtask

   task check(input logic [31:0] v, input logic [31:0] e);
      begin
         compares++;
         if (v !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, v, e);
         end
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      begin
         exp_q.push_back({30'h0, r});
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
         end
         s_axi_bready <= 1'h0;
         if (i == 50) hang();
         @(posedge aclk);
      end
   endtask

   task rd(input logic [31:0] a, input logic [31:0] e);
      int i;
      begin
         exp_q.push_back(e);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
         end
         s_axi_rready <= 1'h0;
         if (i == 50) hang();
         @(posedge aclk);
      end
   endtask

   task frame(input int np, input logic [31:0] e);
      int i;
      begin
         exp_q.push_back(e);
         npulses <= np[5:0];
         start <= 1'h1;
         for (i = 0; i < 4000 && done !== 1'h1; i++) @(posedge aclk);
         start <= 1'h0;
         if (i == 4000) hang();
         @(posedge aclk);
      end
   endtask

   // Word of n bits: position above, special bit last, shifted MSB first
   task run(input int n, input logic g, input logic s, input logic r, input int np);
      logic [31:0] p;
      logic [31:0] c;
      begin
         p = $random(seed);
         wr(32'h0, {19'h0, n[4:0], 5'h0, s, r, g}, 2'h0);
         wr(32'h4, p, 2'h0);
         c = dir_select_n ? p : ~p;
         c = c & ((32'h1 << (n - 1)) - 32'h1);
         if (g) c = c ^ (c >> 1);
         c = (c << 1) | {31'h0, s};
         frame(np, np > n + 1 ? (c << n) | c : c << 1);
      end
   endtask

   always @(posedge aclk) begin
      if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) check({30'h0, s_axi_bresp}, exp_q.pop_front());
      if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) check(s_axi_rdata, exp_q.pop_front());
      if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1)
         check({30'h0, s_axi_rresp}, (s_axi_araddr inside {32'h0, 32'h4, 32'h8}) ? 32'h0 : 32'h2);
      if (done === 1'h1) check(word, exp_q.pop_front());
   end

   initial begin
      seed = 33804;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (4) @(posedge aclk);
      rd(32'h0, 32'h0000_1901);
      rd(32'h8, 32'h0);
      rd(32'hc, 32'h0);
      wr(32'h1000, 32'hffff_ffff, 2'h2);
      wr(32'h8, 32'hffff_ffff, 2'h0);
      for (k = 0; k < 4; k++) begin
         run(lens[k], k[0], k[1], 1'h0, lens[k] + 1);
      end
      run(13, 1'h1, 1'h0, 1'h1, 26);
      run(25, 1'h1, 1'h1, 1'h1, 26);
      dir_select_n <= 1'h0;
      repeat (8) @(posedge aclk);
      rd(32'h8, {16'h0006, 16'h0004});
      run(20, 1'h1, 1'h1, 1'h0, 21);
      if (exp_q.size() != 0) error_cnt++;
      report_and_stop;
   end
endmodule // test_ssi_position_transmitter
`default_nettype wire
